// ---- codec_port_map.vh ----
// register offsets, field positions, reset values and mode codes
// for the codec serial frame port; definitions only
`ifndef CODEC_PORT_MAP_VH
`define CODEC_PORT_MAP_VH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_CTRL_C 8'h08
`define OFS_TX_SLOT 8'h0c
`define OFS_RX_SLOT 8'h10
`define OFS_STATUS 8'h14
`define PAGE_TXBUF 4'h2
`define PAGE_RXBUF 4'h3

// ----------------------------------------------------------------
// port_control_reg_a fields
// ----------------------------------------------------------------
`define CA_EN 0
`define CA_FSDIR 1
`define CA_MODE_LO 2
`define CA_MODE_HI 3
`define CA_BCKDIR 4
`define CA_EDGE 5
`define CA_JUST 6
`define CA_TRIS 7
`define CA_RST 8'h00

// ----------------------------------------------------------------
// port_control_reg_b fields
// ----------------------------------------------------------------
`define CB_WS_LO 0
`define CB_WS_HI 3
`define CB_FG_LO 4
`define CB_FG_HI 7
`define CB_DEPTH_LO 8
`define CB_DEPTH_HI 9
`define CB_RST 10'h000

// ----------------------------------------------------------------
// other reset values and framing constants
// ----------------------------------------------------------------
`define CC_RST 12'h000
`define SLOT_RST 16'h0000
`define MODE_MC 2'h0
`define MODE_I2S 2'h1
`define MODE_AC16 2'h2
`define MODE_AC20 2'h3
`define AC_SYNC_HIGH 9'h010
`define AC_FRAME_LAST 9'h0ff
`define AC_SLOT_LAST 4'hf
`define WORD_16 5'h10
`define WORD_20 5'h14

`endif

// ---- word_bank.v ----
// four 16-bit words with one write port, a bulk load and a
// registered read port; bulk load lands first, a word write on top
`default_nettype none

module word_bank (
    input wire clk_i,              // system clock
    input wire rst_i,              // synchronous reset
    input wire wr_en_i,            // single word write
    input wire [1:0] wr_addr_i,    // word index
    input wire [1:0] wr_be_i,      // byte lanes
    input wire [15:0] wr_data_i,   // write data
    input wire load_i,             // load all four words
    input wire [63:0] load_data_i, // bulk data, word 0 lowest
    input wire [1:0] rd_addr_i,    // read index
    output reg [15:0] rd_data_o,   // registered read data
    output wire [63:0] all_o       // all words, word 0 lowest
);
    reg [63:0] mem_ff;
    reg [63:0] nxt_mem;
    integer i;

    assign all_o = mem_ff;

    always @* begin
        nxt_mem = load_i ? load_data_i : mem_ff;
        for (i = 0; i < 2; i = i + 1) begin
            if (wr_en_i && wr_be_i[i]) begin
                nxt_mem[wr_addr_i*16 + i*8 +: 8] = wr_data_i[i*8 +: 8];
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mem_ff <= 64'h0;
            rd_data_o <= 16'h0;
        end else begin
            mem_ff <= nxt_mem;
            rd_data_o <= mem_ff[rd_addr_i*16 +: 16];
        end
    end
endmodule

`default_nettype wire

// ---- codec_frame_port.v ----
// codec serial frame port: bit clock divider, frame sync master and
// slave, slot timing, shift registers, shadow and cpu buffers.
// assumes a classic wishbone master and pins synchronous to clk_i.
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`default_nettype none
`include "codec_port_map.vh"

module codec_frame_port (
    input wire clk_i,             // system clock
    input wire rst_i,             // synchronous reset
    input wire cyc_i,             // wishbone cycle
    input wire stb_i,             // wishbone strobe
    input wire we_i,              // wishbone write
    input wire [7:0] adr_i,       // byte address
    input wire [3:0] sel_i,       // byte lanes
    input wire [31:0] dat_i,      // write data
    output reg [31:0] dat_o,      // read data
    output reg ack_o,             // wishbone ack
    input wire bit_clock_i,       // bit clock pin in
    output reg bit_clock_o,       // bit clock pin out
    output reg bit_clock_oe_o,    // bit clock drive enable
    input wire frame_sync_i,      // frame sync pin in
    output reg frame_sync_o,      // frame sync pin out
    output reg frame_sync_oe_o,   // frame sync drive enable
    output reg serial_out_o,      // serial data out
    output reg serial_out_oe_o,   // serial data drive enable
    input wire serial_in_i        // serial data in
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function [4:0] word_len;
        input [1:0] m;
        input [3:0] ws;
        input [3:0] s;
        begin
            case (m)
                `MODE_AC16: word_len = `WORD_16;
                `MODE_AC20: word_len = (s == 4'h0) ? `WORD_16 : `WORD_20;
                default: word_len = {1'b0, ws} + 5'h01;
            endcase
        end
    endfunction

    function slot_on;
        input [15:0] bits;
        input [3:0] s;
        input [3:0] last;
        begin
            slot_on = bits[s] && (s <= last);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k]) begin
                    merge[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    reg [7:0] ctrl_a_ff;
    reg [9:0] ctrl_b_ff;
    reg [11:0] div_ff;
    reg [15:0] tx_slot_ff;
    reg [15:0] rx_slot_ff;

    wire en = ctrl_a_ff[`CA_EN];
    wire fs_slave = ctrl_a_ff[`CA_FSDIR];
    wire master = !fs_slave;
    wire [1:0] mode = ctrl_a_ff[`CA_MODE_HI:`CA_MODE_LO];
    wire bck_ext = ctrl_a_ff[`CA_BCKDIR];
    wire edge_rise = ctrl_a_ff[`CA_EDGE];
    wire just = ctrl_a_ff[`CA_JUST];
    wire tris = ctrl_a_ff[`CA_TRIS];
    wire [3:0] ws = ctrl_b_ff[`CB_WS_HI:`CB_WS_LO];
    wire [1:0] depth = ctrl_b_ff[`CB_DEPTH_HI:`CB_DEPTH_LO];
    wire is_ac = mode[1];
    wire [3:0] fg = is_ac ? `AC_SLOT_LAST : ctrl_b_ff[`CB_FG_HI:`CB_FG_LO];

    // ------------------------------------------------------------
    // bit clock: divider or external pin
    // ------------------------------------------------------------
    reg [11:0] bdiv_ff;
    reg bck_in_ff;
    wire gen_on = en && !bck_ext && (div_ff != 12'h000);
    wire tog = gen_on && (bdiv_ff == div_ff);
    wire rise_ev = bck_ext ? (bit_clock_i && !bck_in_ff) : (tog && !bit_clock_o);
    wire fall_ev = bck_ext ? (!bit_clock_i && bck_in_ff) : (tog && bit_clock_o);
    wire samp_ev = en && (edge_rise ? rise_ev : fall_ev);
    wire drv_ev = en && (edge_rise ? fall_ev : rise_ev);

    always @(posedge clk_i) begin
        if (rst_i) begin
            bdiv_ff <= 12'h000;
            bit_clock_o <= 1'b0;
            bit_clock_oe_o <= 1'b0;
            bck_in_ff <= 1'b0;
        end else begin
            bck_in_ff <= bit_clock_i;
            bit_clock_oe_o <= gen_on;
            if (!gen_on) begin
                bdiv_ff <= 12'h000;
                bit_clock_o <= 1'b0;
            end else if (tog) begin
                // half period of div+1 clocks gives clk/(2*(div+1))
                bdiv_ff <= 12'h000;
                bit_clock_o <= !bit_clock_o;
            end else begin
                bdiv_ff <= bdiv_ff + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // frame timing
    // ------------------------------------------------------------
    reg [7:0] pos_ff;
    reg [4:0] bidx_ff;
    reg [3:0] slot_ff;
    reg [1:0] ptr_ff;
    reg active_ff;
    reg start_ff;
    reg fs_in_ff;
    reg tx_on_ff;
    reg [15:0] tx_sh_ff;
    reg [15:0] rx_sh_ff;
    reg [63:0] tx_shadow_ff;
    reg [63:0] rx_shadow_ff;

    wire [4:0] wl = word_len(mode, ws, slot_ff);
    wire [4:0] wl_cfg = word_len(mode, ws, 4'h0);
    wire [9:0] frame_len = wl_cfg * ({1'b0, fg} + 5'h01);
    wire [8:0] frame_last = is_ac ? `AC_FRAME_LAST : frame_len[8:0] - 9'h001;
    wire [8:0] half = frame_len[9:1];
    wire bit_end = (bidx_ff == wl - 5'h01);
    wire frame_end = ({1'b0, pos_ff} == frame_last);
    wire run = master || start_ff || (active_ff && !frame_end);
    wire restart = start_ff || frame_end;
    wire [7:0] nxt_pos = restart ? 8'h00 : pos_ff + 8'h01;
    wire [4:0] nxt_bidx = (restart || bit_end) ? 5'h00 : bidx_ff + 5'h01;
    wire [3:0] nxt_slot = restart ? 4'h0 : (bit_end ? slot_ff + 4'h1 : slot_ff);
    // sync leads the data by one bit unless same-cycle justify is set
    wire [8:0] phase = just ? {1'b0, nxt_pos} :
        (({1'b0, nxt_pos} == frame_last) ? 9'h000 : {1'b0, nxt_pos} + 9'h001);
    wire tx_go = slot_on(tx_slot_ff, nxt_slot, fg);
    wire rx_hit = slot_on(rx_slot_ff, slot_ff, fg);
    wire tx_hit = slot_on(tx_slot_ff, slot_ff, fg);
    wire [15:0] rx_full = {rx_sh_ff[14:0], serial_in_i};
    wire [15:0] rx_word = (wl > `WORD_16) ? rx_sh_ff :
        (rx_full << (`WORD_16 - wl));
    wire fs_hit = (mode == `MODE_I2S) ? (frame_sync_i != fs_in_ff) : frame_sync_i;
    wire word_done = samp_ev && active_ff && bit_end && (rx_hit || tx_hit);
    wire wrap = word_done && (ptr_ff == depth);
    wire [63:0] tx_bank_all;
    reg [63:0] nxt_rx_shadow;

    always @* begin
        nxt_rx_shadow = rx_shadow_ff;
        if (word_done && rx_hit) begin
            nxt_rx_shadow[ptr_ff*16 +: 16] = rx_word;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i || !en) begin
            pos_ff <= 8'h00;
            bidx_ff <= 5'h00;
            slot_ff <= 4'h0;
            ptr_ff <= 2'h0;
            active_ff <= 1'b0;
            start_ff <= 1'b0;
            fs_in_ff <= 1'b0;
            tx_on_ff <= 1'b0;
            tx_sh_ff <= 16'h0000;
            rx_sh_ff <= 16'h0000;
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
            frame_sync_o <= 1'b0;
            frame_sync_oe_o <= 1'b0;
            if (rst_i) begin
                tx_shadow_ff <= 64'h0;
                rx_shadow_ff <= 64'h0;
            end
        end else begin
            frame_sync_oe_o <= master;
            if (drv_ev) begin
                start_ff <= 1'b0;
                active_ff <= run;
                if (run) begin
                    pos_ff <= nxt_pos;
                    bidx_ff <= nxt_bidx;
                    slot_ff <= nxt_slot;
                    if (nxt_bidx == 5'h00) begin
                        tx_on_ff <= tx_go;
                        serial_out_oe_o <= tx_go || !tris;
                        if (tx_go) begin
                            // low bits past the word length are never shifted out
                            tx_sh_ff <= tx_shadow_ff[ptr_ff*16 +: 16];
                            serial_out_o <= tx_shadow_ff[ptr_ff*16 + 15];
                        end else begin
                            serial_out_o <= 1'b0;
                        end
                    end else begin
                        tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
                        serial_out_o <= tx_on_ff && tx_sh_ff[14];
                    end
                end else begin
                    pos_ff <= 8'h00;
                    bidx_ff <= 5'h00;
                    slot_ff <= 4'h0;
                    tx_on_ff <= 1'b0;
                    serial_out_o <= 1'b0;
                    serial_out_oe_o <= !tris;
                end
                if (master) begin
                    case (mode)
                        `MODE_MC: frame_sync_o <= (phase == 9'h000);
                        `MODE_I2S: frame_sync_o <= (phase < half);
                        default: frame_sync_o <= (phase < `AC_SYNC_HIGH);
                    endcase
                end else begin
                    frame_sync_o <= 1'b0;
                end
            end
            if (samp_ev) begin
                fs_in_ff <= frame_sync_i;
                if (active_ff && bidx_ff < `WORD_16) begin
                    rx_sh_ff <= rx_full;
                end
                // a sync that arrives mid-frame is dropped
                if (fs_slave && fs_hit && (!active_ff || frame_end)) begin
                    start_ff <= 1'b1;
                end
            end
            rx_shadow_ff <= nxt_rx_shadow;
            if (word_done) begin
                ptr_ff <= wrap ? 2'h0 : ptr_ff + 2'h1;
            end
            if (wrap) begin
                tx_shadow_ff <= tx_bank_all;
            end
        end
    end

    // ------------------------------------------------------------
    // cpu buffers
    // ------------------------------------------------------------
    wire req = cyc_i && stb_i;
    reg phase_ff;
    wire commit = req && phase_ff && !ack_o;
    wire tx_wr = commit && we_i && (adr_i[7:4] == `PAGE_TXBUF);
    wire [15:0] tx_rd;
    wire [15:0] rx_rd;

    word_bank tx_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(tx_wr),
        .wr_addr_i(adr_i[3:2]),
        .wr_be_i(sel_i[1:0]),
        .wr_data_i(dat_i[15:0]),
        .load_i(1'b0),
        .load_data_i(64'h0),
        .rd_addr_i(adr_i[3:2]),
        .rd_data_o(tx_rd),
        .all_o(tx_bank_all)
    );

    word_bank rx_bank (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(1'b0),
        .wr_addr_i(2'h0),
        .wr_be_i(2'h0),
        .wr_data_i(16'h0000),
        .load_i(wrap),
        .load_data_i(nxt_rx_shadow),
        .rd_addr_i(adr_i[3:2]),
        .rd_data_o(rx_rd),
        .all_o()
    );

    // ------------------------------------------------------------
    // wishbone slave: ack two edges after the request
    // ------------------------------------------------------------
    reg [31:0] rd_mux;
    reg [31:0] wmerge;

    always @* begin
        case (adr_i)
            `OFS_CTRL_A: rd_mux = {24'h0, ctrl_a_ff};
            `OFS_CTRL_B: rd_mux = {22'h0, ctrl_b_ff};
            `OFS_CTRL_C: rd_mux = {20'h0, div_ff};
            `OFS_TX_SLOT: rd_mux = {16'h0, tx_slot_ff};
            `OFS_RX_SLOT: rd_mux = {16'h0, rx_slot_ff};
            `OFS_STATUS: rd_mux = {24'h0, ptr_ff, slot_ff, active_ff, bit_clock_o};
            default: rd_mux = 32'h0;
        endcase
        if (adr_i[7:4] == `PAGE_TXBUF && adr_i[1:0] == 2'h0) begin
            rd_mux = {16'h0, tx_rd};
        end
        if (adr_i[7:4] == `PAGE_RXBUF && adr_i[1:0] == 2'h0) begin
            rd_mux = {16'h0, rx_rd};
        end
        case (adr_i)
            `OFS_CTRL_A: wmerge = merge({24'h0, ctrl_a_ff}, dat_i, sel_i);
            `OFS_CTRL_B: wmerge = merge({22'h0, ctrl_b_ff}, dat_i, sel_i);
            `OFS_CTRL_C: wmerge = merge({20'h0, div_ff}, dat_i, sel_i);
            `OFS_TX_SLOT: wmerge = merge({16'h0, tx_slot_ff}, dat_i, sel_i);
            default: wmerge = merge({16'h0, rx_slot_ff}, dat_i, sel_i);
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_ff <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= 32'h0;
            ctrl_a_ff <= `CA_RST;
            ctrl_b_ff <= `CB_RST;
            div_ff <= `CC_RST;
            tx_slot_ff <= `SLOT_RST;
            rx_slot_ff <= `SLOT_RST;
        end else begin
            ack_o <= commit;
            phase_ff <= req && !ack_o && !phase_ff;
            if (commit) begin
                dat_o <= we_i ? 32'h0 : rd_mux;
                if (we_i) begin
                    case (adr_i)
                        `OFS_CTRL_A: ctrl_a_ff <= wmerge[7:0];
                        `OFS_CTRL_B: ctrl_b_ff <= wmerge[9:0];
                        `OFS_CTRL_C: div_ff <= wmerge[11:0];
                        `OFS_TX_SLOT: tx_slot_ff <= wmerge[15:0];
                        `OFS_RX_SLOT: rx_slot_ff <= wmerge[15:0];
                        default: ;
                    endcase
                end
            end
        end
    end
endmodule

`default_nettype wire

// ---- codec_frame_port_props.sv ----
// checker for codec_frame_port: bus handshake, pin drive, sync widths
// sees only the top ports; bound from the testbench top file
`default_nettype none
module codec_frame_port_props (
    input wire logic clk_i,           // clock
    input wire logic rst_i,           // reset
    input wire logic cyc_i,           // bus cycle
    input wire logic stb_i,           // strobe
    input wire logic we_i,            // write
    input wire logic [7:0] adr_i,     // address
    input wire logic [3:0] sel_i,     // lanes
    input wire logic [31:0] dat_i,    // write data
    input wire logic [31:0] dat_o,    // read data
    input wire logic ack_o,           // ack
    input wire logic bit_clock_oe_o,  // bit clock drive
    input wire logic frame_sync_o,    // sync out
    input wire logic frame_sync_oe_o, // sync drive
    input wire logic serial_out_oe_o  // data drive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctl_ff;
    logic [11:0] div_ff;
    logic [31:0] run_ff;
    logic last_ff;
    logic [1:0] chg_ff;
    wire [31:0] bitp = {19'h0, div_ff, 1'b0} + 32'd2;
    wire run_ok = ctl_ff[0] && !ctl_ff[1] && !ctl_ff[4] && chg_ff == 2'd2 && frame_sync_oe_o;
    // shadow of the control words, taken at the acked write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_ff <= 8'h00;
            div_ff <= 12'h000;
            chg_ff <= 2'd0;
        end else begin
            if (ack_o && we_i && adr_i == 8'h00 && sel_i[0])
                ctl_ff <= dat_i[7:0];
            if (ack_o && we_i && adr_i == 8'h08 && sel_i[1:0] == 2'b11)
                div_ff <= dat_i[11:0];
            if (!frame_sync_oe_o)
                chg_ff <= 2'd0;
            else if (frame_sync_o != last_ff && chg_ff != 2'd2)
                chg_ff <= chg_ff + 2'd1;
        end
        run_ff <= (frame_sync_o != last_ff) ? 32'd1 : run_ff + 32'd1;
        last_ff <= frame_sync_o;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack_o |-> cyc_i && stb_i && $past(cyc_i && stb_i, 2))
        else $error("ack without a held request");
    a_unmapped_zero: assert property (ack_o && (we_i || adr_i[7:6] != 2'b00) |-> dat_o == 32'h0)
        else $error("nonzero data on write or unmapped read");
    a_fs_master: assert property (frame_sync_oe_o |-> ctl_ff[0] && !ctl_ff[1])
        else $error("sync driven while not enabled master");
    a_bck_drive: assert property (bit_clock_oe_o |-> ctl_ff[0] && !ctl_ff[4] && div_ff != 0)
        else $error("bit clock driven when it must not be");
    a_dis_quiet: assert property (!ctl_ff[0] |-> !serial_out_oe_o && !frame_sync_oe_o)
        else $error("pins driven while disabled");
    a_mc_pulse: assert property ($fell(frame_sync_o) && run_ok && ctl_ff[3:2] == 2'b00 |-> run_ff == bitp)
        else $error("multichannel sync not one bit wide");
    a_ac_high: assert property ($fell(frame_sync_o) && run_ok && ctl_ff[3] |-> run_ff == 16 * bitp)
        else $error("link sync high time wrong");
    a_ac_low: assert property ($rose(frame_sync_o) && run_ok && ctl_ff[3] |-> run_ff == 240 * bitp)
        else $error("link sync low time wrong");
    c_ac_frame: cover property ($fell(frame_sync_o) && run_ok && ctl_ff[3]);
    c_mc_frame: cover property ($fell(frame_sync_o) && run_ok && !ctl_ff[3]);
    c_slave_data: cover property (serial_out_oe_o && ctl_ff[1]);
endmodule
`default_nettype wire

// ---- codec_model.sv ----
// codec model: multichannel sync master with its own bit clock;
// sends one word a frame and captures the port's serial output
`default_nettype none
module codec_model (
    input wire logic clk_i,         // system clock
    input wire logic rst_i,         // reset
    input wire logic run_i,         // frames run, clock stops otherwise
    input wire logic [4:0] bits_i,  // bits per frame
    input wire logic [15:0] word_i, // word sent each frame
    input wire logic sdo_i,         // port serial output
    output logic bck_o,             // bit clock
    output logic fs_o,              // frame sync
    output logic sd_o,              // serial data
    output logic [15:0] got_o       // last word captured
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_ff;
    logic [4:0] pos_ff;
    logic [15:0] cap_ff;
    wire [4:0] nxt_pos = (pos_ff >= bits_i - 5'd1) ? 5'd0 : pos_ff + 5'd1;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sd_o <= 1'b0;
            cap_ff <= 16'h0;
            got_o <= 16'h0;
        end
        if (rst_i || !run_i) begin
            div_ff <= 2'd0;
            bck_o <= 1'b0;
            pos_ff <= 5'd0;
            fs_o <= 1'b0;
            if (!rst_i)
                sd_o <= ~sd_o; // idle line keeps changing
        end else begin
            div_ff <= div_ff + 2'd1;
            if (div_ff == 2'd3) begin
                bck_o <= ~bck_o;
                if (!bck_o) begin
                    pos_ff <= nxt_pos;
                    fs_o <= (nxt_pos == bits_i - 5'd1);
                    sd_o <= word_i[4'd15 - nxt_pos[3:0]];
                end else begin
                    cap_ff <= {cap_ff[14:0], sdo_i};
                    if (pos_ff == bits_i - 5'd1)
                        got_o <= {cap_ff[14:0], sdo_i} << (5'd16 - bits_i);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- codec_frame_port_tb.sv ----
// testbench for codec_frame_port: registers, master sync shapes and
// slave frames against codec_model; assumes a 10 MHz system clock
`default_nettype none
module codec_frame_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, bck_o, bck_oe, fs_o, fs_oe, sdo, sdo_oe, m_bck, m_fs, m_sd;
    logic run = 1'b0;
    logic [4:0] bits = 5'd16;
    logic [15:0] word = 16'h0;
    logic [15:0] got;
    int fails = 0;
    int checks = 0;
    always #50 clk_i = ~clk_i;
    codec_frame_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .bit_clock_i(bck_oe ? bck_o : m_bck), .bit_clock_o(bck_o),
        .bit_clock_oe_o(bck_oe), .frame_sync_i(fs_oe ? fs_o : m_fs), .frame_sync_o(fs_o),
        .frame_sync_oe_o(fs_oe), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
        .serial_in_i(m_sd));
    codec_model model (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .bits_i(bits),
        .word_i(word), .sdo_i(sdo_oe ? sdo : 1'bz), .bck_o(m_bck), .fs_o(m_fs),
        .sd_o(m_sd), .got_o(got));
    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            chk("ack", 32'h1, 32'h0);
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(what, e, q);
    endtask
    // counts cycles until the bit clock (pick) or the sync reaches v
    task automatic until_v(input logic pick, input logic v, output int n);
        n = 0;
        while ((pick ? bck_o : fs_o) !== v) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n > 3000) begin
                chk("edge wait", 32'h1, 32'h0);
                final_report();
            end
        end
    endtask
    task automatic master(input logic [1:0] m);
        logic [3:0] ws, fg;
        logic [11:0] d;
        int fr, bp, hi, lo, n;
        ws = {3'($urandom_range(0, 7)), 1'b1};
        fg = 4'($urandom_range(0, 3));
        d = 12'($urandom_range(1, 2));
        fr = (ws + 1) * (fg + 1);
        bp = 2 * (d + 1);
        hi = (m == 2'd0) ? 1 : (m == 2'd1) ? fr / 2 : 16;
        lo = (m == 2'd0) ? fr - 1 : (m == 2'd1) ? fr / 2 : 240;
        wr(8'h00, 32'h0);
        wr(8'h04, {24'h0, fg, ws});
        rdc("ctrl b", 8'h04, {24'h0, fg, ws});
        wr(8'h08, {20'h0, d});
        wr(8'h00, {24'h0, 3'($urandom), 1'b0, m, 2'b01});
        until_v(1'b0, 1'b1, n);
        until_v(1'b0, 1'b0, n);
        until_v(1'b0, 1'b1, n);
        chk("sync low", lo * bp, n);
        until_v(1'b0, 1'b0, n);
        chk("sync high", hi * bp, n);
        until_v(1'b1, 1'b1, n);
        until_v(1'b1, 1'b0, n);
        chk("bit clock high", d + 1, n);
        $display("master mode %0d done", m);
    endtask
    task automatic slave;
        logic [3:0] ws;
        logic [15:0] tx, mask;
        ws = 4'($urandom_range(3, 15));
        tx = 16'($urandom);
        mask = 16'hffff << (4'd15 - ws);
        wr(8'h00, 32'h0);
        wr(8'h04, {28'h0, ws});
        wr(8'h08, 32'($urandom_range(1, 4095)));
        wr(8'h0c, 32'h0000ffff);
        wr(8'h10, 32'h0000ffff);
        wr(8'h20, {16'h0, tx});
        bits <= 5'(ws) + 5'd1;
        word <= 16'($urandom);
        run <= 1'b1;
        wr(8'h00, 32'h00000013);
        repeat (40 * (ws + 1)) @(posedge clk_i);
        chk("tx word", {16'h0, tx & mask}, {16'h0, got});
        rdc("rx word", 8'h30, {16'h0, word & mask});
        run <= 1'b0;
        $display("slave word size %0d done", ws + 1);
    endtask
    initial begin
        logic [31:0] q;
        q = $urandom(32'h057251e3);
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) rdc("reset value", 8'(i * 4), 32'h0);
        wr(8'h18, 32'hffffffff);
        rdc("unmapped", 8'h18, 32'h0);
        wr(8'h00, 32'h00000001);
        repeat (20) @(posedge clk_i);
        chk("divider zero drive", 32'h0, {31'h0, bck_oe});
        $display("registers done");
        for (int m = 0; m < 4; m++) master(2'(m));
        repeat (3) slave();
        final_report();
    end
endmodule
bind codec_frame_port codec_frame_port_props props_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .bit_clock_oe_o(bit_clock_oe_o),
    .frame_sync_o(frame_sync_o), .frame_sync_oe_o(frame_sync_oe_o),
    .serial_out_oe_o(serial_out_oe_o));
`default_nettype wire
